// >>> logic/rba_bank.v
// One register word holding a field of every software bit-access type.
`include "rba_defines.vh"
`default_nettype none

// Contract
// - A read/write field reads back its stored value and takes written data.
// - A read-only field reads its live value and ignores software writes.
// - A write-only field stores writes but always reads as its reset value.
// - A clear-on-one flag is readable, clears on a written one, keeps on zero.
// - A clear-on-zero flag is readable, clears on a written zero, keeps on one.
// - A clear-on-read flag returns its value on a read then clears itself.
// - A set-only flag is readable, is set by a written one, only hw clears it.
// - A write-trigger bit reads its state; any write pulses its event only.
// - A toggle bit inverts on a written one and keeps its value on zero.
module rba_bank (
  // Clock and reset.
  input wire clk,
  input wire rstn,
  // Software register port.
  input wire sw_wr,
  input wire [`RBA_BE_W-1:0] sw_be,
  input wire [`RBA_DATA_W-1:0] sw_wdata,
  input wire sw_rd,
  output reg [`RBA_DATA_W-1:0] sw_rdata,
  output reg sw_rvalid,
  // Plain read/write field.
  output reg [`RBA_RW_MSB-`RBA_RW_LSB:0] rw_value,
  // Read-only field source.
  input wire [`RBA_RO_MSB-`RBA_RO_LSB:0] ro_value,
  // Write-only field.
  output reg [`RBA_WO_MSB-`RBA_WO_LSB:0] wo_value,
  // Clear-on-one flags.
  input wire [`RBA_FLAG_W-1:0] clear_on_one_set,
  output wire [`RBA_FLAG_W-1:0] clear_on_one_bit,
  // Clear-on-zero flags.
  input wire [`RBA_FLAG_W-1:0] clear_on_zero_set,
  output wire [`RBA_FLAG_W-1:0] clear_on_zero_bit,
  // Clear-on-read flags.
  input wire [`RBA_FLAG_W-1:0] clear_on_read_set,
  output wire [`RBA_FLAG_W-1:0] clear_on_read_bit,
  // Set-only flags and their hardware clear.
  input wire [`RBA_FLAG_W-1:0] set_only_clr,
  output wire [`RBA_FLAG_W-1:0] set_only_bit,
  // Write-trigger bits: state from hardware, event pulse out.
  input wire [`RBA_FLAG_W-1:0] trigger_state,
  output reg [`RBA_FLAG_W-1:0] trigger_on_write_bit,
  // Toggle bits.
  output reg [`RBA_FLAG_W-1:0] toggle_value
);

  // Expands byte enables into a per-bit write mask.
  // Each lane is eight bits wide, so lane k covers bits 8k up to 8k+7.
  function [`RBA_DATA_W-1:0] lane_mask;
    input [`RBA_BE_W-1:0] be;
    integer i;
    begin
      lane_mask = {`RBA_DATA_W{1'b0}};
      for (i = 0; i < `RBA_DATA_W; i = i + 1)
      begin
        lane_mask[i] = be[i / `RBA_LANE_W];
      end
    end
  endfunction

  // Write mask and qualified write data, shared by all writable fields.
  wire [`RBA_DATA_W-1:0] wr_mask;
  wire [`RBA_DATA_W-1:0] wr_ones;
  wire [`RBA_DATA_W-1:0] wr_zeros;
  wire [`RBA_DATA_W-1:0] rd_word;
  wire [`RBA_FLAG_W-1:0] c1_clr;
  wire [`RBA_FLAG_W-1:0] c0_clr;
  wire [`RBA_FLAG_W-1:0] cr_clr;
  wire [`RBA_FLAG_W-1:0] so_set;
  // Next values of the fields that software owns.
  reg [`RBA_RW_MSB-`RBA_RW_LSB:0] next_rw_value;
  reg [`RBA_WO_MSB-`RBA_WO_LSB:0] next_wo_value;
  reg [`RBA_FLAG_W-1:0] next_toggle_value;

  // Only enabled byte lanes of a write take effect.
  // Ones and zeros are kept apart because some flags react to each one.
  assign wr_mask = sw_wr ? lane_mask(sw_be) : {`RBA_DATA_W{1'b0}};
  assign wr_ones = wr_mask & sw_wdata;
  assign wr_zeros = wr_mask & ~sw_wdata;

  // Flag clears and sets derived from the same write, or from the read for clear-on-read, bit by bit.
  // A flag set in the cycle of its read survives, so no event is lost.
  assign c1_clr = wr_ones[`RBA_C1_MSB:`RBA_C1_LSB];
  assign c0_clr = wr_zeros[`RBA_C0_MSB:`RBA_C0_LSB];
  assign cr_clr = sw_rd ? clear_on_read_bit : {`RBA_FLAG_W{1'b0}};
  assign so_set = wr_ones[`RBA_SO_MSB:`RBA_SO_LSB];

  // Clear-on-one flags: hardware sets, a written one clears.
  rba_flag_cell #(
    .WIDTH(`RBA_FLAG_W),
    .RST(`RBA_C1_RST)
  ) u_c1 (
    .clk(clk),
    .rstn(rstn),
    .set(clear_on_one_set),
    .clr(c1_clr),
    .q(clear_on_one_bit)
  );

  // Clear-on-zero flags: hardware sets, a written zero clears.
  rba_flag_cell #(
    .WIDTH(`RBA_FLAG_W),
    .RST(`RBA_C0_RST)
  ) u_c0 (
    .clk(clk),
    .rstn(rstn),
    .set(clear_on_zero_set),
    .clr(c0_clr),
    .q(clear_on_zero_bit)
  );

  // Clear-on-read flags: writes never reach them, a read clears.
  rba_flag_cell #(
    .WIDTH(`RBA_FLAG_W),
    .RST(`RBA_CR_RST)
  ) u_cr (
    .clk(clk),
    .rstn(rstn),
    .set(clear_on_read_set),
    .clr(cr_clr),
    .q(clear_on_read_bit)
  );

  // Set-only flags: software sets, only hardware clears.
  // A software set in the cycle of a hardware clear wins.
  rba_flag_cell #(
    .WIDTH(`RBA_FLAG_W),
    .RST(`RBA_SO_RST)
  ) u_so (
    .clk(clk),
    .rstn(rstn),
    .set(so_set),
    .clr(set_only_clr),
    .q(set_only_bit)
  );

  // Next values of the software-owned fields, each under its own lane mask.
  // Bits outside an enabled lane keep their value.
  always @*
  begin
    next_rw_value = (rw_value & ~wr_mask[`RBA_RW_MSB:`RBA_RW_LSB])
      | wr_ones[`RBA_RW_MSB:`RBA_RW_LSB];
    next_wo_value = (wo_value & ~wr_mask[`RBA_WO_MSB:`RBA_WO_LSB])
      | wr_ones[`RBA_WO_MSB:`RBA_WO_LSB];
    next_toggle_value = toggle_value
      ^ wr_ones[`RBA_TG_MSB:`RBA_TG_LSB];
  end

  // Storage of the read/write, write-only and toggle fields.
  // Reset values come from the shared field constants.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rw_value <= `RBA_RW_RST;
      wo_value <= `RBA_WO_RST;
      toggle_value <= `RBA_TG_RST;
    end
    else
    begin
      rw_value <= next_rw_value;
      wo_value <= next_wo_value;
      toggle_value <= next_toggle_value;
    end
  end

  // Trigger pulses: any enabled write fires them, whatever the data bit.
  // The pulse lasts one cycle; the readable state comes from trigger_state.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      trigger_on_write_bit <= {`RBA_FLAG_W{1'b0}};
    end
    else
    begin
      trigger_on_write_bit <= wr_mask[`RBA_TR_MSB:`RBA_TR_LSB];
    end
  end

  // Read word: write-only reads its reset value, reserved reads zero.
  // The last item of the concatenation lands in the lowest bits.
  assign rd_word = {
    `RBA_RES_VAL,
    toggle_value,
    trigger_state,
    set_only_bit,
    clear_on_read_bit,
    clear_on_zero_bit,
    clear_on_one_bit,
    `RBA_WO_RST,
    ro_value,
    rw_value
  };

  // Read data register: captures the word before any same-cycle change.
  // Read data hold until the next read, so a late consumer still sees them.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      sw_rdata <= {`RBA_DATA_W{1'b0}};
      sw_rvalid <= 1'b0;
    end
    else
    begin
      sw_rvalid <= sw_rd;
      if (sw_rd)
      begin
        sw_rdata <= rd_word;
      end
    end
  end

endmodule

`default_nettype wire

// >>> logic/rba_defines.vh
// Field layout, reset values and lane constants of the bit-access register.
`ifndef RBA_DEFINES_VH
`define RBA_DEFINES_VH

// Bus word and byte-lane geometry.
`define RBA_DATA_W 32
`define RBA_BE_W 4
`define RBA_LANE_W 8

// Plain read/write field, byte lane 0.
`define RBA_RW_LSB 0
`define RBA_RW_MSB 7
`define RBA_RW_RST 8'h00

// Read-only field, byte lane 1 low nibble.
`define RBA_RO_LSB 8
`define RBA_RO_MSB 11

// Write-only field, byte lane 1 high nibble.
`define RBA_WO_LSB 12
`define RBA_WO_MSB 15
`define RBA_WO_RST 4'h0

// Hardware-set flags cleared by writing one, byte lane 2.
`define RBA_C1_LSB 16
`define RBA_C1_MSB 17
`define RBA_C1_RST 2'h0

// Hardware-set flags cleared by writing zero, byte lane 2.
`define RBA_C0_LSB 18
`define RBA_C0_MSB 19
`define RBA_C0_RST 2'h0

// Hardware-set flags cleared by a read, byte lane 2.
`define RBA_CR_LSB 20
`define RBA_CR_MSB 21
`define RBA_CR_RST 2'h0

// Software-set flags cleared by hardware, byte lane 2.
`define RBA_SO_LSB 22
`define RBA_SO_MSB 23
`define RBA_SO_RST 2'h0

// Write-trigger bits, byte lane 3.
`define RBA_TR_LSB 24
`define RBA_TR_MSB 25

// Toggle bits, byte lane 3.
`define RBA_TG_LSB 26
`define RBA_TG_MSB 27
`define RBA_TG_RST 2'h0

// Reserved bits, byte lane 3, read as zero.
`define RBA_RES_LSB 28
`define RBA_RES_MSB 31
`define RBA_RES_VAL 4'h0

// Pair of bits per flag field.
`define RBA_FLAG_W 2

`endif

// >>> logic/rba_flag_cell.v
// Group of sticky flags with a set and a clear input, set winning.
`default_nettype none

module rba_flag_cell #(
  parameter integer WIDTH = 2,
  parameter [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
  // Clock and reset.
  input wire clk,
  input wire rstn,
  // Set and clear requests, one bit per flag.
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  // Current flag values.
  output reg [WIDTH-1:0] q
);

  wire [WIDTH-1:0] next_q;

  // A set arriving in the cycle of a clear is kept: set has priority.
  assign next_q = (q & ~clr) | set;

  // Flag storage with synchronous active-low reset.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      q <= RST;
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

// >>> tb/rba_bank_monitor.sv
// Concurrent checks on the ports of the bit-access register.
`default_nettype none
module rba_bank_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Software port.
  input wire logic sw_wr,
  input wire logic [3:0] sw_be,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic sw_rvalid,
  // Fields.
  input wire logic [7:0] rw_value,
  input wire logic [3:0] ro_value,
  // Flags and their hardware sets.
  input wire logic [1:0] clear_on_one_set,
  input wire logic [1:0] clear_on_one_bit,
  input wire logic [1:0] clear_on_zero_set,
  input wire logic [1:0] clear_on_zero_bit,
  input wire logic [1:0] clear_on_read_set,
  input wire logic [1:0] clear_on_read_bit,
  input wire logic [1:0] set_only_bit,
  input wire logic [1:0] trigger_on_write_bit,
  input wire logic [1:0] toggle_value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Lane-qualified write strobes.
  wire w0 = sw_wr & sw_be[0];
  wire w2 = sw_wr & sw_be[2];
  wire w3 = sw_wr & sw_be[3];
  a_rw_take: assert property (w0 |=> rw_value == $past(sw_wdata[7:0]))
    else $error("rw field missed write");
  a_rw_hold: assert property (!w0 |=> $stable(rw_value))
    else $error("rw field changed without write");
  a_ro_read: assert property (sw_rd |=> sw_rvalid
    && sw_rdata[11:8] == $past(ro_value))
    else $error("ro field read wrong");
  a_wo_read: assert property (sw_rvalid |-> sw_rdata[15:12] == 4'h0)
    else $error("wo field read not reset value");
  a_c1_clear: assert property (w2 && sw_wdata[16] && !clear_on_one_set[0]
    |=> !clear_on_one_bit[0])
    else $error("clear on one flag kept");
  a_c0_clear: assert property (w2 && !sw_wdata[18] && !clear_on_zero_set[0]
    |=> !clear_on_zero_bit[0])
    else $error("clear on zero flag kept");
  a_cr_clear: assert property (sw_rd && !clear_on_read_set[0]
    |=> !clear_on_read_bit[0])
    else $error("clear on read flag kept");
  a_so_set: assert property (w2 && sw_wdata[22] |=> set_only_bit[0])
    else $error("set only flag not set");
  a_trig_pulse: assert property (w3 |=> trigger_on_write_bit == 2'h3)
    else $error("trigger pulse missing");
  a_trig_quiet: assert property (!w3 |=> trigger_on_write_bit == 2'h0)
    else $error("trigger pulse without write");
  a_tog_flip: assert property (w3 && sw_wdata[26]
    |=> toggle_value[0] != $past(toggle_value[0]))
    else $error("toggle bit not flipped");
endmodule
bind rba_bank rba_bank_monitor mon (
  .clk(clk),
  .rstn(rstn),
  .sw_wr(sw_wr),
  .sw_be(sw_be),
  .sw_wdata(sw_wdata),
  .sw_rd(sw_rd),
  .sw_rdata(sw_rdata),
  .sw_rvalid(sw_rvalid),
  .rw_value(rw_value),
  .ro_value(ro_value),
  .clear_on_one_set(clear_on_one_set),
  .clear_on_one_bit(clear_on_one_bit),
  .clear_on_zero_set(clear_on_zero_set),
  .clear_on_zero_bit(clear_on_zero_bit),
  .clear_on_read_set(clear_on_read_set),
  .clear_on_read_bit(clear_on_read_bit),
  .set_only_bit(set_only_bit),
  .trigger_on_write_bit(trigger_on_write_bit),
  .toggle_value(toggle_value)
);
`default_nettype wire

// >>> tb/rba_bank_tb.sv
// Self-checking bench for the bit-access register word.
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module rba_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rstn = 1'h0, sw_wr = 1'h0, sw_rd = 1'h0;
  logic [3:0] sw_be = 4'h0, ro_value = 4'h9;
  logic [31:0] sw_wdata = 32'h0;
  logic [1:0] clear_on_one_set = 2'h0, clear_on_zero_set = 2'h0;
  logic [1:0] clear_on_read_set = 2'h0, set_only_clr = 2'h0;
  logic [1:0] trigger_state = 2'h2;
  wire [31:0] sw_rdata;
  wire sw_rvalid;
  wire [7:0] rw_value;
  wire [3:0] wo_value;
  wire [1:0] clear_on_one_bit, clear_on_zero_bit, clear_on_read_bit;
  wire [1:0] set_only_bit, trigger_on_write_bit, toggle_value;
  int n_errors = 0, checks_done = 0, cyc = 0;
  rba_bank uut (
    .clk(clk),
    .rstn(rstn),
    .sw_wr(sw_wr),
    .sw_be(sw_be),
    .sw_wdata(sw_wdata),
    .sw_rd(sw_rd),
    .sw_rdata(sw_rdata),
    .sw_rvalid(sw_rvalid),
    .rw_value(rw_value),
    .ro_value(ro_value),
    .wo_value(wo_value),
    .clear_on_one_set(clear_on_one_set),
    .clear_on_one_bit(clear_on_one_bit),
    .clear_on_zero_set(clear_on_zero_set),
    .clear_on_zero_bit(clear_on_zero_bit),
    .clear_on_read_set(clear_on_read_set),
    .clear_on_read_bit(clear_on_read_bit),
    .set_only_clr(set_only_clr),
    .set_only_bit(set_only_bit),
    .trigger_state(trigger_state),
    .trigger_on_write_bit(trigger_on_write_bit),
    .toggle_value(toggle_value)
  );
  // Clock and hang guard.
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One write cycle; returns just after the edge that takes it.
  task wr(input [3:0] be, input [31:0] d);
    @(posedge clk) #1;
    {sw_wr, sw_be, sw_wdata} = {1'h1, be, d};
    @(posedge clk) #1;
    sw_wr = 1'h0;
  endtask
  // One read cycle, compared while the valid pulse stands.
  task rd(input [31:0] e);
    @(posedge clk) #1;
    sw_rd = 1'h1;
    @(posedge clk) #1;
    sw_rd = 1'h0;
    `CHK("rvalid", 1'h1, sw_rvalid)
    `CHK("rdata", e, sw_rdata)
  endtask
  // One-cycle hardware set pulse on the three flag groups.
  task hw(input [5:0] s);
    @(posedge clk) #1;
    {clear_on_one_set, clear_on_zero_set, clear_on_read_set} = s;
    @(posedge clk) #1;
    {clear_on_one_set, clear_on_zero_set, clear_on_read_set} = 6'h0;
  endtask
  task t_fields();
    rd(32'h0200_0900);
    wr(4'h3, 32'h0000_f0a5);
    `CHK("rw", 8'ha5, rw_value)
    `CHK("wo", 4'hf, wo_value)
    ro_value = 4'h6;
    wr(4'he, 32'h0000_0fff);
    `CHK("rw_mask", 8'ha5, rw_value)
    rd(32'h0200_06a5);
  endtask
  task t_flags();
    hw(6'h3c);
    wr(4'h4, 32'h0049_0000);
    `CHK("c1", 2'h2, clear_on_one_bit)
    `CHK("c0", 2'h2, clear_on_zero_bit)
    `CHK("so", 2'h1, set_only_bit)
  endtask
  task t_cor();
    hw(6'h03);
    wr(4'h4, 32'h0030_0000);
    `CHK("cr_wr", 2'h3, clear_on_read_bit)
    rd(32'h0272_06a5);
    `CHK("cr_rd", 2'h0, clear_on_read_bit)
  endtask
  // Hardware clear of the set-only flags, then a software set of bit 1.
  task t_so();
    @(posedge clk) #1;
    set_only_clr = 2'h3;
    @(posedge clk) #1;
    set_only_clr = 2'h0;
    `CHK("so_clr", 2'h0, set_only_bit)
    wr(4'h4, 32'h0080_0000);
    `CHK("so_set", 2'h2, set_only_bit)
  endtask
  task t_trig();
    wr(4'h8, 32'h0400_0000);
    `CHK("trg1", 2'h3, trigger_on_write_bit)
    `CHK("tog1", 2'h1, toggle_value)
    @(posedge clk) #1;
    `CHK("trg0", 2'h0, trigger_on_write_bit)
    wr(4'h8, 32'h0);
    `CHK("trg2", 2'h3, trigger_on_write_bit)
    `CHK("tog2", 2'h1, toggle_value)
    wr(4'h8, 32'h0c00_0000);
    `CHK("tog3", 2'h2, toggle_value)
    rd(32'h0a82_06a5);
  endtask
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'h1;
    t_fields();
    t_flags();
    t_cor();
    t_so();
    t_trig();
    summarize();
  end
endmodule
`default_nettype wire
